// ===== common/ppic_pkg.sv
// package for the power and interrupt control register block
`default_nettype none
package ppic_pkg;
	localparam logic [4:0] CTRL_ADDR = 5'h11;
	localparam logic [4:0] EVENT_ADDR = 5'h12;
	localparam logic [15:0] CTRL_RESET = 16'h0108;
	localparam logic [15:0] CTRL_WMASK = 16'hFB0F;
	localparam logic [15:0] EVENT_RESET = 16'h0000;
	localparam int BIT_CLK_OFF = 15;
	localparam int BIT_LP_EN = 14;
	localparam int BIT_LP_SEL_HI = 13;
	localparam int BIT_LP_SEL_LO = 12;
	localparam int BIT_SCR_SKIP = 11;
	localparam int BIT_LB_HI = 9;
	localparam int BIT_LB_LO = 8;
	localparam int BIT_POL = 3;
	localparam int BIT_FORCE = 2;
	localparam int BIT_EV_EN = 1;
	localparam int BIT_PIN_DRV = 0;
	localparam int EV_STAT_LO = 8;
	localparam int EV_EN_HI = 7;
	localparam int EV_LINK = 5;
	localparam logic [1:0] LP_NORMAL = 2'h0;
	localparam logic [1:0] LP_SLEEP = 2'h2;
	localparam logic [3:0] LB_DEPTH_0 = 4'h4;
	localparam logic [3:0] LB_DEPTH_1 = 4'h5;
	localparam logic [3:0] LB_DEPTH_2 = 4'h6;
	localparam logic [3:0] LB_DEPTH_3 = 4'h8;
	localparam int CLOCK_HZ = 125_000_000;
	localparam int PULSE_MS = 1400;
	localparam longint PULSE_CYCLES_L = longint'(CLOCK_HZ) * PULSE_MS / 1000;
	localparam logic [31:0] PULSE_CYCLES = PULSE_CYCLES_L[31:0];
	typedef struct packed {
		logic clk_off;
		logic sleeping;
		logic scr_skip;
		logic [3:0] lb_depth;
	} ppic_ctrl_t;
endpackage
`default_nettype wire

// ===== rtl/ppic_pulse_timer.sv
// periodic link pulse timer used while asleep
`default_nettype none
module ppic_pulse_timer #(
	parameter logic [31:0] PERIOD = ppic_pkg::PULSE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic run_in,
	output logic pulse_out
);
	logic [31:0] count;
	// restart on each entry so the first pulse is one full period after sleep
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= 32'h0000_0000;
			pulse_out <= 1'b0;
		end else if (!run_in) begin
			count <= 32'h0000_0000;
			pulse_out <= 1'b0;
		end else if (count == PERIOD - 32'h0000_0001) begin
			count <= 32'h0000_0000;
			pulse_out <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			pulse_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ppic_ctrl.sv
// power save, loopback depth and interrupt control register
`default_nettype none
module ppic_ctrl #(
	parameter logic [31:0] PULSE_PERIOD = ppic_pkg::PULSE_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	input wire logic [4:0] REG_ADDR_IN,
	input wire logic REG_WRITE_IN,
	input wire logic REG_READ_IN,
	input wire logic [15:0] REG_WDATA_IN,
	output logic [15:0] REG_RDATA_OUT,
	input wire logic STD_POWERDOWN_IN,
	input wire logic PARTNER_DETECT_IN,
	input wire logic [7:0] EVENT_IN,
	input wire logic IRQ_PIN_IN,
	output logic IRQ_PIN_OUT,
	output logic IRQ_PIN_OE_OUT,
	output logic PIN_POWERDOWN_OUT,
	output logic LINK_PULSE_OUT,
	output logic CORE_POWER_OFF_OUT,
	output var ppic_pkg::ppic_ctrl_t CTRL_OUT
);
	typedef enum logic [1:0] {
		PPIC_AWAKE = 2'b01,
		PPIC_ASLEEP = 2'b10
	} ppic_state_t;

	logic [15:0] ctrl;
	logic [7:0] ev_stat;
	logic [7:0] ev_en;
	logic irq_pend;
	logic sleep_req;
	logic asleep;
	logic link_pulse;
	ppic_state_t state;
	ppic_state_t next_state;

	function automatic logic [3:0] lb_nibbles(input logic [1:0] code);
		unique case (code)
			2'h0: lb_nibbles = ppic_pkg::LB_DEPTH_0;
			2'h1: lb_nibbles = ppic_pkg::LB_DEPTH_1;
			2'h2: lb_nibbles = ppic_pkg::LB_DEPTH_2;
			2'h3: lb_nibbles = ppic_pkg::LB_DEPTH_3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl <= ppic_pkg::CTRL_RESET;
		end else if (REG_WRITE_IN && REG_ADDR_IN == ppic_pkg::CTRL_ADDR) begin
			ctrl <= REG_WDATA_IN & ppic_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ev_en <= ppic_pkg::EVENT_RESET[7:0];
		end else if (REG_WRITE_IN && REG_ADDR_IN == ppic_pkg::EVENT_ADDR) begin
			ev_en <= REG_WDATA_IN[ppic_pkg::EV_EN_HI:0];
		end
	end

	// event latches clear on read; a new event in the read cycle still sets
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ev_stat <= 8'h00;
		end else if (REG_READ_IN && REG_ADDR_IN == ppic_pkg::EVENT_ADDR) begin
			ev_stat <= EVENT_IN;
		end else begin
			ev_stat <= ev_stat | EVENT_IN;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			REG_RDATA_OUT <= 16'h0000;
		end else if (REG_READ_IN) begin
			unique case (REG_ADDR_IN)
				ppic_pkg::CTRL_ADDR: REG_RDATA_OUT <= ctrl;
				ppic_pkg::EVENT_ADDR: REG_RDATA_OUT <= {ev_stat, ev_en};
				default: REG_RDATA_OUT <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power save sequencing
	assign sleep_req = ctrl[ppic_pkg::BIT_LP_EN] &&
		ctrl[ppic_pkg::BIT_LP_SEL_HI:ppic_pkg::BIT_LP_SEL_LO] == ppic_pkg::LP_SLEEP;

	always_comb begin
		next_state = state;
		unique case (state)
			PPIC_AWAKE: if (sleep_req && !PARTNER_DETECT_IN) next_state = PPIC_ASLEEP;
			PPIC_ASLEEP: if (!sleep_req || PARTNER_DETECT_IN) next_state = PPIC_AWAKE;
			default: next_state = PPIC_AWAKE;
		endcase
	end

	// wake leaves the enable set; sleep resumes once the partner goes away
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state <= PPIC_AWAKE;
		end else begin
			state <= next_state;
		end
	end

	assign asleep = state == PPIC_ASLEEP;

	ppic_pulse_timer #(.PERIOD(PULSE_PERIOD)) u_timer (
		.clk_in(CLOCK_IN),
		.rst_b_in(RST_B_IN),
		.run_in(asleep),
		.pulse_out(link_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// interrupt and outputs
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			irq_pend <= 1'b0;
		end else begin
			irq_pend <= ctrl[ppic_pkg::BIT_FORCE] ||
				(ctrl[ppic_pkg::BIT_EV_EN] && |(ev_stat & ev_en));
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			IRQ_PIN_OUT <= 1'b1;
			IRQ_PIN_OE_OUT <= 1'b0;
			PIN_POWERDOWN_OUT <= 1'b0;
			LINK_PULSE_OUT <= 1'b0;
			CORE_POWER_OFF_OUT <= 1'b0;
			CTRL_OUT <= '0;
		end else begin
			IRQ_PIN_OUT <= irq_pend ^ ctrl[ppic_pkg::BIT_POL];
			IRQ_PIN_OE_OUT <= ctrl[ppic_pkg::BIT_PIN_DRV];
			PIN_POWERDOWN_OUT <= !ctrl[ppic_pkg::BIT_PIN_DRV] && !IRQ_PIN_IN;
			LINK_PULSE_OUT <= link_pulse;
			CORE_POWER_OFF_OUT <= asleep;
			CTRL_OUT.clk_off <= ctrl[ppic_pkg::BIT_CLK_OFF] && STD_POWERDOWN_IN;
			CTRL_OUT.sleeping <= asleep;
			CTRL_OUT.scr_skip <= ctrl[ppic_pkg::BIT_SCR_SKIP];
			CTRL_OUT.lb_depth <= lb_nibbles(ctrl[ppic_pkg::BIT_LB_HI:ppic_pkg::BIT_LB_LO]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// forced request held over two edges; pending shows one edge later, the pin one more
	sequence force_held_s;
		ctrl[ppic_pkg::BIT_FORCE] ##1 ctrl[ppic_pkg::BIT_FORCE];
	endsequence

	// quiet read of the event register, no new event racing the clear
	sequence event_read_s;
		REG_READ_IN && REG_ADDR_IN == ppic_pkg::EVENT_ADDR && EVENT_IN == 8'h00;
	endsequence

	reset_value_a: assert property (@(posedge CLOCK_IN) $rose(RST_B_IN) |-> ctrl == ppic_pkg::CTRL_RESET)
		else $error("control reset value wrong");
	clk_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		CTRL_OUT.clk_off |-> $past(STD_POWERDOWN_IN)) else $error("clock off outside power-down");
	sleep_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		asleep |-> $past(ctrl[ppic_pkg::BIT_LP_EN])) else $error("asleep without enable");
	lp_off_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		!ctrl[ppic_pkg::BIT_LP_EN] |=> !asleep) else $error("asleep with power save off");
	sleep_sel_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		(sleep_req && !PARTNER_DETECT_IN && !asleep) |=> asleep) else $error("sleep not entered");
	core_off_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		CORE_POWER_OFF_OUT |-> $past(asleep)) else $error("core off while awake");
	pulse_sleep_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		link_pulse |-> $past(asleep)) else $error("link pulse while awake");
	wake_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		(asleep && PARTNER_DETECT_IN) |=> !asleep) else $error("no wake on partner");
	scr_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		##1 CTRL_OUT.scr_skip == $past(ctrl[ppic_pkg::BIT_SCR_SKIP])) else $error("scrambler skip mismatch");
	lb_max_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		$past(ctrl[ppic_pkg::BIT_LB_HI:ppic_pkg::BIT_LB_LO]) == 2'h3 |-> CTRL_OUT.lb_depth == ppic_pkg::LB_DEPTH_3)
		else $error("loopback depth wrong");
	lb_min_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		$past(ctrl[ppic_pkg::BIT_LB_HI:ppic_pkg::BIT_LB_LO]) == 2'h0 |-> CTRL_OUT.lb_depth == ppic_pkg::LB_DEPTH_0)
		else $error("shallow loopback depth wrong");
	polarity_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		force_held_s |=> IRQ_PIN_OUT != $past(ctrl[ppic_pkg::BIT_POL]))
		else $error("forced interrupt not signalled");
	idle_level_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		!irq_pend |=> IRQ_PIN_OUT == $past(ctrl[ppic_pkg::BIT_POL])) else $error("interrupt idle level wrong");
	ev_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		(!ctrl[ppic_pkg::BIT_FORCE] && !ctrl[ppic_pkg::BIT_EV_EN]) |=> !irq_pend) else $error("event not gated");
	pin_dir_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		IRQ_PIN_OE_OUT |-> !PIN_POWERDOWN_OUT) else $error("pin both input and output");
	pd_input_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		(!ctrl[ppic_pkg::BIT_PIN_DRV] && !IRQ_PIN_IN) |=> PIN_POWERDOWN_OUT) else $error("power-down input missed");
	rd_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		event_read_s |=> ev_stat == 8'h00) else $error("read did not clear events");
	ev_sticky_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		EVENT_IN != 8'h00 |=> (ev_stat & $past(EVENT_IN)) == $past(EVENT_IN)) else $error("event lost");
	reserved_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
		(ctrl & ~ppic_pkg::CTRL_WMASK) == 16'h0000) else $error("reserved bits set");
endmodule
`default_nettype wire

// ===== dv/ppic_host.sv
// management host model driving the register strobe bus
`default_nettype none
module ppic_host (
	input wire logic clk_in,
	input wire logic [15:0] rdata_in,
	output logic [4:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_out = 5'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	////////////////////////////////////////////////////////////////
	// depth choice is left to the caller, nothing is checked here
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		// released data is inverted so stale values never look valid
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ===== dv/phy_power_irq_control_bench.sv
// self-checking bench for the power and interrupt control register
`default_nettype none
module phy_power_irq_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PER = 32'h0000_0010;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic std_pd = 1'b0;
	logic partner = 1'b0;
	logic pd_low = 1'b0;
	logic [7:0] events = 8'h00;
	logic [4:0] addr;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] d;
	logic pin_out;
	logic pin_oe;
	logic pin_pd;
	logic pulse;
	logic poff;
	int n;
	int miscompares = 0;
	int n_tests = 0;
	ppic_pkg::ppic_ctrl_t ctrl;
	// undriven pin is pulled up; the bench pulls it low for power-down
	wire logic pin = pin_oe ? pin_out : ~pd_low;
	always #4 clock_in = ~clock_in;
	ppic_host i_host (.clk_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wr_out(reg_wr), .rd_out(reg_rd),
		.wdata_out(wdata));
	ppic_ctrl #(.PULSE_PERIOD(PER)) i_dut (.CLOCK_IN(clock_in), .RST_B_IN(rst_b_in), .REG_ADDR_IN(addr),
		.REG_WRITE_IN(reg_wr), .REG_READ_IN(reg_rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.STD_POWERDOWN_IN(std_pd), .PARTNER_DETECT_IN(partner), .EVENT_IN(events), .IRQ_PIN_IN(pin),
		.IRQ_PIN_OUT(pin_out), .IRQ_PIN_OE_OUT(pin_oe), .PIN_POWERDOWN_OUT(pin_pd), .LINK_PULSE_OUT(pulse),
		.CORE_POWER_OFF_OUT(poff), .CTRL_OUT(ctrl));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge clock_in);
	endtask
	// bounded wait, a missing pulse ends the run
	task automatic wait_pulse(output int c);
		c = 0;
		while (pulse !== 1'b1 && c < 40) begin
			@(negedge clock_in);
			c++;
		end
		if (c >= 40) begin
			miscompares++;
			close_out();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_fields();
		logic [3:0] depth [3] = '{4'h4, 4'h5, 4'h6};
		i_host.rd(5'h11, d);
		check("ctrl reset", d, 16'h0108);
		i_host.rd(5'h03, d);
		check("unmapped", d, 16'h0000);
		check("reset depth", 16'(ctrl.lb_depth), 16'h0005);
		i_host.wr(5'h11, 16'hFFFF);
		idle(3);
		i_host.rd(5'h11, d);
		check("reserved bits", d, 16'hFB0F);
		check("scr skip", 16'(ctrl.scr_skip), 16'h0001);
		check("depth 3", 16'(ctrl.lb_depth), 16'h0008);
		check("sel 3 awake", 16'(ctrl.sleeping), 16'h0000);
		check("clk off no pd", 16'(ctrl.clk_off), 16'h0000);
		std_pd = 1'b1;
		idle(3);
		check("clk off in pd", 16'(ctrl.clk_off), 16'h0001);
		std_pd = 1'b0;
		for (int i = 0; i < 3; i++) begin
			i_host.wr(5'h11, 16'(i) << 8);
			idle(3);
			check("depth code", 16'(ctrl.lb_depth), 16'(depth[i]));
		end
		check("scr on", 16'(ctrl.scr_skip), 16'h0000);
	endtask
	task automatic t_irq();
		for (int p = 0; p < 2; p++) begin
			i_host.wr(5'h11, 16'h0005 | (16'(p) << 3));
			idle(4);
			check("forced pin", 16'(pin_out), 16'(p == 0));
			check("pin driven", 16'(pin_oe), 16'h0001);
			i_host.wr(5'h11, 16'h0001 | (16'(p) << 3));
			i_host.rd(5'h12, d);
			idle(4);
			check("forced stop", 16'(pin_out), 16'(p));
		end
		i_host.wr(5'h11, 16'h0008);
		pd_low = 1'b1;
		idle(4);
		check("pd input", 16'(pin_pd), 16'h0001);
		pd_low = 1'b0;
		idle(4);
		check("pd released", 16'(pin_pd), 16'h0000);
	endtask
	task automatic t_event();
		i_host.wr(5'h12, 16'h0020);
		for (int e = 0; e < 2; e++) begin
			i_host.wr(5'h11, 16'h0009 | (16'(e) << 1));
			@(negedge clock_in);
			events = 8'h20;
			@(negedge clock_in);
			events = 8'h00;
			idle(4);
			check("event pin", 16'(pin_out), 16'(e == 0));
			i_host.rd(5'h12, d);
			check("event status", d, 16'h2020);
			idle(4);
			check("read clears", 16'(pin_out), 16'h0001);
		end
	endtask
	task automatic t_sleep();
		i_host.wr(5'h11, 16'h6008);
		idle(3);
		check("asleep", 16'(poff), 16'h0001);
		check("sleep flag", 16'(ctrl.sleeping), 16'h0001);
		wait_pulse(n);
		@(negedge clock_in);
		wait_pulse(n);
		check("pulse gap", 16'(n + 1), PER[15:0]);
		partner = 1'b1;
		idle(3);
		check("wake", 16'(poff), 16'h0000);
		partner = 1'b0;
		idle(3);
		check("re-sleep", 16'(poff), 16'h0001);
		i_host.wr(5'h11, 16'h5008);
		idle(3);
		check("sel 1 awake", 16'(poff), 16'h0000);
		i_host.wr(5'h11, 16'h6008);
		idle(3);
		check("sel 2 asleep", 16'(poff), 16'h0001);
		i_host.wr(5'h11, 16'h2008);
		idle(3);
		check("lp off", 16'(poff), 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		idle(4);
		rst_b_in = 1'b1;
		idle(2);
		t_fields();
		t_irq();
		t_event();
		t_sleep();
		close_out();
	end
endmodule
`default_nettype wire
